// *** hdl/fapc_regs.svh ***
// Register offsets, field positions and reset values of the flash port controller
`ifndef FAPC_REGS_SVH
`define FAPC_REGS_SVH

`define FAPC_SEL_BANK1_CFG   1'b0
`define FAPC_SEL_ACC_PROT    1'b1

`define FAPC_B1_P0_EN        0
`define FAPC_B1_P1_EN        1
`define FAPC_B1_RWW_LSB      5
`define FAPC_B1_RWS_LSB      8
`define FAPC_BANK1_REQUEST_HOLD_CYCLES_LSB      13
`define FAPC_B1_MASK         32'h0003_ffe3
`define FAPC_B1_RESET        32'h0003_ffe3

`define FAPC_AP_ARB_LSB      6
`define FAPC_AP_PFD_LSB      8
`define FAPC_AP_RIGHTS_LSB   16
`define FAPC_AP_KEEP         32'hffff_ffc0
`define FAPC_AP_RESET        32'hffff_ffc0

`define FAPC_SHADOW_ADDR     24'h203e00
`define FAPC_HTRANS_NONSEQ   2'h2
`define FAPC_BANK1_ENTRY     4'h8

`define FAPC_RWW_STALL_NOTE  3'h6
`define FAPC_RWW_ABORT_QUIET 3'h5
`define FAPC_RWW_ABORT_NOTE  3'h4

`endif

// *** hdl/fapc_pkg.sv ***
// Types shared by the flash port controller
package fapc_pkg;
	typedef enum logic [2:0] {
		FAPC_IDLE = 3'h0,
		FAPC_REQ  = 3'h1,
		FAPC_WAIT = 3'h3,
		FAPC_LOOK = 3'h2,
		FAPC_ERR1 = 3'h6,
		FAPC_ERR2 = 3'h7
	} fapc_port_e;

	typedef enum logic [1:0] {
		FAPC_B_ISSUE = 2'h0,
		FAPC_B_WAIT  = 2'h1,
		FAPC_B_DONE  = 2'h3
	} fapc_boot_e;

	typedef struct packed {
		logic [23:0] addr;
		logic [4:0]  ew;
		logic [1:0]  bank;
		logic        write;
		logic [2:0]  master;
		logic        instr;
		logic [2:0]  size;
		logic        pf;
	} fapc_req_s;
endpackage

// *** hdl/fapc_ctrl.sv ***
// Two-port flash controller: protection, arbitration, holding buffers, bank strobes
//
// Function
// - Bank1 hold field inserts N idle cycles between successive array requests.
// - Bank1 read wait field adds 0..31 wait states to array read time.
// - Bank1 read during program stalls; codes select stall note, abort, abort note.
// - Clearing a bank1 port holding enable invalidates it; hits remain possible only in the cycle after a fill.
// - Protection register loads from shadow word 0x203E00 at reset; writes last.
// - Arbitration field bits 6-7: 00 port0 first, 01 port1 first, 1x round-robin.
// - Ports addressing different banks are served concurrently without arbitration.
// - Per-master bits 8-15 block prefetch, further qualified by prefetch enables.
// - Bits 16-31: two bits per master, 00 none, 01 read, 10 write, 11 both.
// - A transfer violating master rights ends with an AHB error response.
// - Three bank interfaces carry enables, address, size, data; read data returns.
// - Per port, bank0 keeps four buffers, bank1 one holding register; bank2 fills target entries 8-11 and never hit.
// - Reads hitting stored data complete with zero wait states.
// - Each new array request pulses the enable with address for one edge.
// - Enables stay low while idle; the next request may follow next cycle.
// - Each access ends after its bank's programmed read or write wait count.
// - Address bits 28:24 add emulation wait states to reads and writes.
// - Nonzero emulation bits suppress next-line prefetch and buffer hits.
// - Non-sequential access with nonzero emulation bits invalidates the buffers.
// - Error: response with ready low one cycle, then both high until ready in.
// - A protection violation starts no array access.
`timescale 1ns/1ns
`include "fapc_regs.svh"
module fapc_ctrl #(
	parameter int         DW               = 64,
	parameter logic [4:0] BANK02_READ_WAIT = 5'h02,
	parameter logic [4:0] WRITE_WAIT       = 5'h02,
	parameter logic [4:0] BANK02_HOLD      = 5'h00
) (
	input  wire logic                 clock,                  // System clock
	input  wire logic                 rst,                    // Async reset, active high
	input  wire logic                 cfg_wr,                 // Register write strobe
	input  wire logic                 cfg_sel,                // Register select
	input  wire logic [31:0]          cfg_wdata,              // Register write data
	output logic      [31:0]          cfg_rdata,              // Selected register value
	input  wire logic [1:0]           hsel,                   // AHB select per port
	input  wire logic [1:0][31:0]     haddr,                  // AHB address
	input  wire logic [1:0][1:0]      htrans,                 // AHB transfer type
	input  wire logic [1:0]           hwrite,                 // AHB write
	input  wire logic [1:0][2:0]      hsize,                  // AHB size
	input  wire logic [1:0][DW-1:0]   hwdata,                 // AHB write data
	input  wire logic [1:0][2:0]      hmaster,                // Master number
	input  wire logic [1:0][3:0]      hprot,                  // AHB protection
	input  wire logic [1:0]           hready_in,              // AHB ready in
	output logic      [1:0]           hready_out,             // AHB ready out
	output logic      [1:0]           hresp,                  // AHB error response
	output logic      [1:0][DW-1:0]   hrdata,                 // AHB read data
	input  wire logic [1:0]           data_prefetch_enable,   // Bank0/2 data prefetch
	input  wire logic [1:0]           instr_prefetch_enable,  // Bank0/2 fetch prefetch
	input  wire logic [1:0]           bank02_buf_enable,      // Bank0/2 buffer enable
	output logic      [2:0]           bank_array_read_strobe, // Array read enable
	output logic      [2:0]           bank_array_write_strobe,// Array write enable
	output logic      [2:0][23:0]     bank_array_address,     // Array address
	output logic      [2:0][2:0]      bank_write_size,        // Array write size
	output logic      [2:0][DW-1:0]   bank_write_data,        // Array write data
	input  wire logic [2:0][DW-1:0]   bank_read_data,         // Array read data
	input  wire logic                 bank1_prog_busy,        // Bank1 program/erase busy
	output logic                      bank1_rww_abort,        // Abort bank1 operation
	output logic                      rww_stall_note,         // Stall notification pulse
	output logic                      rww_abort_note          // Abort notification pulse
);
	localparam int NE = 9;

	function automatic logic [1:0] bank_of(input logic [23:0] a);
		bank_of = (a[23:22] == 2'h0) ? 2'h0 : (a[23:22] == 2'h1) ? 2'h1 : 2'h2;
	endfunction

	function automatic logic in_bank(input int e, input logic [1:0] b);
		in_bank = (b == 2'h1) ? (e == 8) : (b == 2'h0) ? (e < 4) : (e >= 4 && e < 8);
	endfunction

	function automatic logic rights_ok(input logic [31:0] ap, input logic [2:0] m,
			input logic w);
		rights_ok = ap[`FAPC_AP_RIGHTS_LSB + 2 * int'(m) + int'(w)];
	endfunction

	fapc_pkg::fapc_port_e st [2];
	fapc_pkg::fapc_port_e next_st [2];
	fapc_pkg::fapc_req_s  cur [2];
	fapc_pkg::fapc_req_s  next_cur [2];
	fapc_pkg::fapc_req_s  dem [2];
	fapc_pkg::fapc_req_s  next_dem [2];
	fapc_pkg::fapc_req_s  pfq [2];
	fapc_pkg::fapc_req_s  next_pfq [2];
	fapc_pkg::fapc_req_s  live [2];
	fapc_pkg::fapc_req_s  src [2];
	fapc_pkg::fapc_boot_e boot;
	fapc_pkg::fapc_boot_e next_boot;
	logic [6:0]           cnt [2];
	logic [6:0]           next_cnt [2];
	logic [6:0]           bcnt;
	logic [6:0]           next_bcnt;
	logic [1:0]           dem_pend, next_dem_pend, pf_pend, next_pf_pend;
	logic [1:0]           stalled, next_stalled;
	logic [1:0]           next_hready, next_hresp;
	logic [1:0][DW-1:0]   next_hrdata;
	logic [1:0]           want, gnt, viol, hit_take, take_live, decide;
	logic [NE-1:0]        val [2];
	logic [NE-1:0]        next_val [2];
	logic [20:0]          tag [2][NE];
	logic [20:0]          next_tag [2][NE];
	logic [DW-1:0]        dat [2][NE];
	logic [DW-1:0]        next_dat [2][NE];
	logic [1:0]           rr [2][2];
	logic [1:0]           next_rr [2][2];
	logic [3:0]           hidx [2];
	logic [3:0]           fidx;
	logic [2:0]           busy, next_busy, rr_last, next_rr_last, bank_free;
	logic [2:0][4:0]      gap, next_gap;
	logic [2:0]           next_rd, next_wr;
	logic [2:0][23:0]     next_addr;
	logic [2:0][2:0]      next_wsize;
	logic [2:0][DW-1:0]   next_wdata;
	logic [31:0]          cfg1, next_cfg1, prot, next_prot, next_cfg_rdata;
	logic                 next_abort, next_stall_note, next_abort_note, pick1;
	logic [2:0]           rww;
	logic [1:0]           arb;

	assign rww = cfg1[`FAPC_B1_RWW_LSB +: 3];
	assign arb = prot[`FAPC_AP_ARB_LSB +: 2];

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_cur = cur;
		next_dem = dem;
		next_pfq = pfq;
		next_cnt = cnt;
		next_dem_pend = dem_pend;
		next_pf_pend = pf_pend;
		next_stalled = stalled;
		next_hready = hready_out;
		next_hresp = hresp;
		next_hrdata = hrdata;
		next_val = val;
		next_tag = tag;
		next_dat = dat;
		next_rr = rr;
		next_busy = busy;
		next_rr_last = rr_last;
		next_gap = gap;
		next_rd = '0;
		next_wr = '0;
		next_addr = bank_array_address;
		next_wsize = bank_write_size;
		next_wdata = bank_write_data;
		next_cfg1 = cfg1;
		next_prot = prot;
		next_boot = boot;
		next_bcnt = bcnt;
		next_abort = 1'b0;
		next_stall_note = 1'b0;
		next_abort_note = 1'b0;
		next_cfg_rdata = (cfg_sel == `FAPC_SEL_ACC_PROT) ? prot : cfg1;
		gnt = '0;
		fidx = 4'h0;
		pick1 = 1'b0;
		if (cfg_wr) begin
			if (cfg_sel == `FAPC_SEL_ACC_PROT)
				next_prot = cfg_wdata & `FAPC_AP_KEEP;
			else
				next_cfg1 = cfg_wdata & `FAPC_B1_MASK;
		end
		// Boot fetch of the protection word from the shadow area
		unique case (boot)
			fapc_pkg::FAPC_B_ISSUE: begin
				next_rd[0] = 1'b1;
				next_addr[0] = `FAPC_SHADOW_ADDR;
				next_bcnt = 7'(BANK02_READ_WAIT);
				next_boot = fapc_pkg::FAPC_B_WAIT;
			end
			fapc_pkg::FAPC_B_WAIT: begin
				if (bcnt == 7'h0) begin
					next_prot = bank_read_data[0][31:0] & `FAPC_AP_KEEP;
					next_boot = fapc_pkg::FAPC_B_DONE;
				end else begin
					next_bcnt = bcnt - 7'h1;
				end
			end
			fapc_pkg::FAPC_B_DONE: begin
			end
			default: next_boot = fapc_pkg::FAPC_B_ISSUE;
		endcase
		for (int p = 0; p < 2; p++) begin
			if (!cfg1[`FAPC_B1_P0_EN + p])
				next_val[p][8] = 1'b0;
			if (!bank02_buf_enable[p])
				next_val[p][7:0] = '0;
			want[p] = (st[p] == fapc_pkg::FAPC_REQ) && !(cur[p].bank == 2'h1 &&
				!cur[p].write && bank1_prog_busy);
			live[p] = '{addr: haddr[p][23:0], ew: haddr[p][28:24],
				bank: bank_of(haddr[p][23:0]), write: hwrite[p], master: hmaster[p],
				instr: !hprot[p][0], size: hsize[p], pf: 1'b0};
			take_live[p] = hsel[p] && htrans[p][1] && hready_in[p] &&
				(boot == fapc_pkg::FAPC_B_DONE);
			src[p] = (st[p] == fapc_pkg::FAPC_LOOK) ? dem[p] : live[p];
			decide[p] = (st[p] == fapc_pkg::FAPC_LOOK) ||
				(st[p] == fapc_pkg::FAPC_IDLE && take_live[p]);
			viol[p] = decide[p] && !rights_ok(prot, src[p].master, src[p].write);
			hidx[p] = 4'h0;
			hit_take[p] = 1'b0;
			for (int e = 0; e < NE; e++) begin
				if (in_bank(e, src[p].bank) && val[p][e] && tag[p][e] == src[p].addr[23:3]) begin
					hit_take[p] = decide[p] && !viol[p] && !src[p].write &&
						src[p].ew == 5'h0;
					hidx[p] = 4'(e);
				end
			end
		end
		// Bank request arbitration, each bank on its own
		for (int b = 0; b < 3; b++) begin
			if (gap[b] != 5'h0)
				next_gap[b] = gap[b] - 5'h1;
			bank_free[b] = !busy[b] && gap[b] == 5'h0 && boot == fapc_pkg::FAPC_B_DONE;
			if (bank_free[b]) begin
				if (want[0] && cur[0].bank == 2'(b) && want[1] && cur[1].bank == 2'(b))
					pick1 = (arb == 2'h1) || (arb[1] && !rr_last[b]);
				else
					pick1 = want[1] && cur[1].bank == 2'(b);
				if (want[int'(pick1)] && cur[int'(pick1)].bank == 2'(b)) begin
					gnt[int'(pick1)] = 1'b1;
					next_busy[b] = 1'b1;
					next_rr_last[b] = pick1;
					next_rd[b] = !cur[int'(pick1)].write;
					next_wr[b] = cur[int'(pick1)].write;
					next_addr[b] = cur[int'(pick1)].addr;
					next_wsize[b] = cur[int'(pick1)].size;
					next_wdata[b] = hwdata[int'(pick1)];
				end
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (take_live[p] && htrans[p] == `FAPC_HTRANS_NONSEQ && live[p].ew != 5'h0)
				next_val[p] = '0;
			if ((st[p] == fapc_pkg::FAPC_REQ || st[p] == fapc_pkg::FAPC_WAIT) &&
					cur[p].pf && take_live[p]) begin
				next_dem[p] = live[p];
				next_dem_pend[p] = 1'b1;
				next_hready[p] = 1'b0;
			end
			unique case (st[p])
				fapc_pkg::FAPC_IDLE, fapc_pkg::FAPC_LOOK: begin
					next_hready[p] = (boot == fapc_pkg::FAPC_B_DONE);
					next_hresp[p] = 1'b0;
					next_st[p] = fapc_pkg::FAPC_IDLE;
					if (viol[p]) begin
						next_hready[p] = 1'b0;
						next_hresp[p] = 1'b1;
						next_st[p] = fapc_pkg::FAPC_ERR1;
					end else if (hit_take[p]) begin
						next_hrdata[p] = dat[p][hidx[p]];
					end else if (decide[p]) begin
						next_cur[p] = src[p];
						next_hready[p] = 1'b0;
						next_st[p] = fapc_pkg::FAPC_REQ;
					end else if (pf_pend[p]) begin
						next_cur[p] = pfq[p];
						next_pf_pend[p] = 1'b0;
						next_st[p] = fapc_pkg::FAPC_REQ;
					end
				end
				fapc_pkg::FAPC_REQ: begin
					if (!want[p] && !stalled[p]) begin
						next_stalled[p] = 1'b1;
						next_stall_note = (rww == `FAPC_RWW_STALL_NOTE);
						next_abort = (rww == `FAPC_RWW_ABORT_QUIET) ||
							(rww == `FAPC_RWW_ABORT_NOTE);
						next_abort_note = (rww == `FAPC_RWW_ABORT_NOTE);
					end
					if (gnt[p]) begin
						next_stalled[p] = 1'b0;
						next_cnt[p] = 7'(cur[p].write ? WRITE_WAIT : (cur[p].bank == 2'h1) ?
							cfg1[`FAPC_B1_RWS_LSB +: 5] : BANK02_READ_WAIT) +
							7'(cur[p].ew);
						next_st[p] = fapc_pkg::FAPC_WAIT;
					end
				end
				fapc_pkg::FAPC_WAIT: begin
					if (cnt[p] != 7'h0) begin
						next_cnt[p] = cnt[p] - 7'h1;
					end else begin
						next_busy[cur[p].bank] = 1'b0;
						next_gap[cur[p].bank] = (cur[p].bank == 2'h1) ?
							cfg1[`FAPC_BANK1_REQUEST_HOLD_CYCLES_LSB +: 5] : BANK02_HOLD;
						if (!cur[p].write) begin
							if (cur[p].bank == 2'h1) begin
								fidx = `FAPC_BANK1_ENTRY;
							end else begin
								fidx = {cur[p].bank[1], 1'b0, rr[p][cur[p].bank[1]]};
								next_rr[p][cur[p].bank[1]] = rr[p][cur[p].bank[1]] + 2'h1;
							end
							next_val[p][fidx] = 1'b1;
							next_tag[p][fidx] = cur[p].addr[23:3];
							next_dat[p][fidx] = bank_read_data[cur[p].bank];
						end
						if (!cur[p].pf) begin
							next_hready[p] = 1'b1;
							next_hrdata[p] = bank_read_data[cur[p].bank];
						end
						next_pfq[p] = '{addr: cur[p].addr + 24'h8, ew: 5'h0, bank: cur[p].bank,
							write: 1'b0, master: cur[p].master, instr: cur[p].instr,
							size: cur[p].size, pf: 1'b1};
						next_pf_pend[p] = !cur[p].write && !cur[p].pf && cur[p].bank != 2'h1 &&
							cur[p].ew == 5'h0 && bank02_buf_enable[p] &&
							!prot[`FAPC_AP_PFD_LSB + int'(cur[p].master)] &&
							(cur[p].instr ? instr_prefetch_enable[p] : data_prefetch_enable[p]);
						next_st[p] = next_dem_pend[p] ? fapc_pkg::FAPC_LOOK : fapc_pkg::FAPC_IDLE;
						next_dem_pend[p] = 1'b0;
					end
				end
				fapc_pkg::FAPC_ERR1: begin
					next_hready[p] = 1'b1;
					next_st[p] = fapc_pkg::FAPC_ERR2;
				end
				fapc_pkg::FAPC_ERR2: begin
					if (hready_in[p]) begin
						next_hresp[p] = 1'b0;
						next_st[p] = fapc_pkg::FAPC_IDLE;
					end
				end
				default: next_st[p] = fapc_pkg::FAPC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '{fapc_pkg::FAPC_IDLE, fapc_pkg::FAPC_IDLE};
			cur <= '{'0, '0};
			dem <= '{'0, '0};
			pfq <= '{'0, '0};
			cnt <= '{7'h0, 7'h0};
			val <= '{'0, '0};
			rr <= '{'{2'h0, 2'h0}, '{2'h0, 2'h0}};
			{dem_pend, pf_pend, stalled, hready_out, hresp} <= '0;
			hrdata <= '0;
			{busy, rr_last, bank_array_read_strobe, bank_array_write_strobe} <= '0;
			gap <= '0;
			bank_array_address <= '0;
			bank_write_size <= '0;
			bank_write_data <= '0;
			cfg1 <= `FAPC_B1_RESET;
			prot <= `FAPC_AP_RESET;
			cfg_rdata <= '0;
			boot <= fapc_pkg::FAPC_B_ISSUE;
			bcnt <= 7'h0;
			{bank1_rww_abort, rww_stall_note, rww_abort_note} <= '0;
		end else begin
			st <= next_st;
			cur <= next_cur;
			dem <= next_dem;
			pfq <= next_pfq;
			cnt <= next_cnt;
			val <= next_val;
			rr <= next_rr;
			{dem_pend, pf_pend, stalled} <= {next_dem_pend, next_pf_pend, next_stalled};
			hready_out <= next_hready;
			hresp <= next_hresp;
			hrdata <= next_hrdata;
			{busy, rr_last, gap} <= {next_busy, next_rr_last, next_gap};
			bank_array_read_strobe <= next_rd;
			bank_array_write_strobe <= next_wr;
			bank_array_address <= next_addr;
			bank_write_size <= next_wsize;
			bank_write_data <= next_wdata;
			{cfg1, prot, cfg_rdata} <= {next_cfg1, next_prot, next_cfg_rdata};
			{boot, bcnt} <= {next_boot, next_bcnt};
			bank1_rww_abort <= next_abort;
			rww_stall_note <= next_stall_note;
			rww_abort_note <= next_abort_note;
		end
	end

	// Buffer contents carry no reset; validity is cleared instead
	always_ff @(posedge clock) begin
		tag <= next_tag;
		dat <= next_dat;
	end

	////////////////////////////////////////////////////////////////////////////
	AST_STROBE_ONE_EDGE: assert property (@(posedge clock) disable iff (rst)
		bank_array_read_strobe[1] |-> busy[1] ##1 !bank_array_read_strobe[1])
		else $error("bank1 read strobe longer than one cycle");
	AST_ERR_TWO_PHASE: assert property (@(posedge clock) disable iff (rst)
		(hresp[0] && !hready_out[0]) |=> hresp[0] && hready_out[0])
		else $error("error response second phase missing");
	AST_VIOL_ERROR: assert property (@(posedge clock) disable iff (rst)
		viol[0] |=> hresp[0] && !hready_out[0])
		else $error("violation not answered with error");
	AST_VIOL_NO_ACCESS: assert property (@(posedge clock) disable iff (rst)
		viol[0] |=> st[0] == fapc_pkg::FAPC_ERR1 && !gnt[0] ##1 !gnt[0])
		else $error("violation led to array access");
	AST_HIT_ZERO_WAIT: assert property (@(posedge clock) disable iff (rst)
		hit_take[0] |=> hready_out[0] && !hresp[0])
		else $error("buffer hit not zero wait");
	AST_FIXED_P0: assert property (@(posedge clock) disable iff (rst)
		(want == 2'h3 && cur[0].bank == cur[1].bank && bank_free[cur[0].bank] &&
		arb == 2'h0) |-> gnt == 2'h1)
		else $error("port0 priority not honoured");
	AST_CONCURRENT: assert property (@(posedge clock) disable iff (rst)
		(want == 2'h3 && cur[0].bank != cur[1].bank && bank_free[cur[0].bank] &&
		bank_free[cur[1].bank]) |-> gnt == 2'h3)
		else $error("different banks not served together");
	AST_HOLD_GAP: assert property (@(posedge clock) disable iff (rst)
		($fell(busy[1]) && cfg1[`FAPC_BANK1_REQUEST_HOLD_CYCLES_LSB +: 5] != 5'h0) |=>
		!bank_array_read_strobe[1] && !bank_array_write_strobe[1])
		else $error("bank1 request issued inside hold gap");
	AST_EMU_NO_HIT: assert property (@(posedge clock) disable iff (rst)
		(decide[0] && src[0].ew != 5'h0 && !viol[0]) |=> !hready_out[0])
		else $error("emulated access served from buffer");
endmodule

// *** tb/fapc_flash_model.sv ***
// Flash array banks answering read strobes with address-derived lines
`timescale 1ns/1ns
module fapc_flash_model #(
	parameter logic [31:0] SHADOW = 32'hff87_003f // Boot protection word
) (
	input  wire logic             clock,  // System clock
	input  wire logic [2:0]       rd_stb, // Array read strobes
	input  wire logic [2:0][23:0] addr,   // Array addresses
	output logic      [2:0][63:0] rdata   // Array read data
);
	// Line captured on the strobe and held until the next read of that bank
	always_ff @(posedge clock) begin
		for (int b = 0; b < 3; b++) begin
			if (rd_stb[b]) begin
				rdata[b] <= (addr[b] == 24'h203e00) ? {32'h0, SHADOW}
					: {8'ha5, addr[b], 8'h5a, addr[b]};
			end
		end
	end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the flash port controller
`timescale 1ns/1ns
module tb;
	typedef struct {logic [2:0] m; logic w; logic [31:0] a; logic e; int lat; int stb;} fapc_row_s;
	localparam logic [31:0] PROT = 32'hff87_0000;
	logic             clock = 0, rst = 1, cfg_wr = 0, cfg_sel = 0, rww_stall_note, rww_abort_note;
	logic [31:0]      cfg_wdata = 0, cfg_rdata;
	logic [1:0]       hsel = 0, hwrite = 0, hready_out, hresp, hready_in;
	logic [1:0][31:0] haddr = 0;
	logic [1:0][1:0]  htrans = 0;
	logic [1:0][2:0]  hmaster = 0;
	logic [1:0][63:0] hwdata = 0, hrdata;
	logic [2:0]       rd_stb, wr_stb;
	logic [2:0][23:0] bank_addr;
	logic [2:0][63:0] bank_rdata;
	logic             bank1_prog_busy = 0, bank1_rww_abort;
	logic [23:0]      last_a;
	int               failures = 0, tests_run = 0, nstb = 0, lat;
	fapc_row_s        rows [14];
	assign hready_in = hready_out;
	always #50 clock = ~clock;
	fapc_ctrl u_fapc_ctrl (.clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize({2{3'h3}}), .hwdata(hwdata), .hmaster(hmaster), .hprot({2{4'h1}}),
		.hready_in(hready_in), .hready_out(hready_out), .hresp(hresp), .hrdata(hrdata),
		.data_prefetch_enable(2'h0), .instr_prefetch_enable(2'h0), .bank02_buf_enable(2'h3),
		.bank_array_read_strobe(rd_stb), .bank_array_write_strobe(wr_stb),
		.bank_array_address(bank_addr), .bank_write_size(), .bank_write_data(),
		.bank_read_data(bank_rdata), .bank1_prog_busy(bank1_prog_busy),
		.bank1_rww_abort(bank1_rww_abort), .rww_stall_note(rww_stall_note),
		.rww_abort_note(rww_abort_note));
	fapc_flash_model u_fapc_flash_model (.clock(clock), .rd_stb(rd_stb), .addr(bank_addr),
		.rdata(bank_rdata));
	always @(posedge clock) begin
		for (int b = 0; b < 3; b++) begin
			if (rd_stb[b] | wr_stb[b]) begin
				nstb++;
				last_a = bank_addr[b];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_n(input string n, input int e, input int g);
		tests_run++;
		if (g != e) begin
			failures++;
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cfg(input logic s, input logic [31:0] d);
		@(posedge clock);
		#1 {cfg_sel, cfg_wr, cfg_wdata} = {s, 1'b1, d};
		@(posedge clock);
		#1 cfg_wr = 0;
		@(posedge clock);
		#1;
	endtask
	task automatic wait_boot;
		for (int i = 0; i < 50 && hready_out[0] !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		chk("boot ready", 1, hready_out[0]);
		@(posedge clock);
		#1 cfg_sel = 1;
		@(posedge clock);
		#1 chk("protection after boot", PROT, cfg_rdata);
		cfg_sel = 0;
		@(posedge clock);
		#1 chk("bank1 config reset", 32'h0003_ffe3, cfg_rdata);
	endtask
	// One transfer on port 0; expects latency, response, strobes and data
	task automatic xfer(input fapc_row_s r);
		repeat (4) @(posedge clock);
		#1 {hsel[0], htrans[0], haddr[0], hwrite[0], hmaster[0]} = {1'b1, 2'h2, r.a, r.w, r.m};
		nstb = 0;
		@(posedge clock);
		#1 {hsel[0], htrans[0], hwdata[0]} = {1'b0, 2'h0, 32'h0, r.a};
		lat = 1;
		while (hready_out[0] !== 1'b1 && lat < 100) begin
			@(posedge clock);
			#1 lat++;
		end
		chk_n("latency", r.lat, lat);
		chk("error response", r.e, hresp[0]);
		chk_n("array strobes", r.stb, nstb);
		if (r.stb != 0) chk("array address", r.a[23:0], last_a);
		if (!r.e && !r.w) chk("read data", {8'ha5, r.a[23:0], 8'h5a, r.a[23:0]}, hrdata[0]);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(100 * 5000);
		failures++;
		wrap_up();
	end
	initial begin
		rows = '{'{0, 0, 32'h0040_0000, 0, 5, 1}, '{0, 0, 32'h0040_0000, 0, 1, 0},
			'{1, 1, 32'h0040_0010, 1, 2, 0}, '{2, 0, 32'h0040_0010, 1, 2, 0},
			'{3, 1, 32'h0040_0020, 0, 5, 1}, '{3, 0, 32'h0040_0020, 1, 2, 0},
			'{0, 0, 32'h0340_0008, 0, 8, 1}, '{0, 0, 32'h0340_0008, 0, 8, 1},
			'{1, 0, 32'h0000_0100, 0, 5, 1}, '{1, 0, 32'h0000_0100, 0, 1, 0},
			'{0, 0, 32'h0300_0200, 0, 8, 1}, '{1, 0, 32'h0000_0100, 0, 5, 1},
			'{0, 0, 32'h0080_0100, 0, 5, 1}, '{0, 1, 32'h0080_0108, 0, 5, 1}};
		repeat (16) @(posedge clock);
		#1 rst = 0;
		wait_boot();
		// Equal hold and read wait of 2, both holding registers on
		cfg(0, 32'h0000_42e3);
		chk("bank1 config write", 32'h0000_42e3, cfg_rdata);
		foreach (rows[i]) xfer(rows[i]);
		// Both ports at once: different banks, then the same bank
		repeat (4) @(posedge clock);
		#1 {hsel, htrans, hwrite, hmaster, haddr} = {2'h3, 4'ha, 2'h0, 6'h0, 32'h0080_0400,
			32'h0000_0400};
		@(posedge clock);
		#1 {hsel, htrans} = '0;
		repeat (4) @(posedge clock);
		#1 chk("concurrent ready", 2'h3, hready_out);
		chk("port1 read data", {8'ha5, 24'h80_0400, 8'h5a, 24'h80_0400}, hrdata[1]);
		repeat (4) @(posedge clock);
		#1 {hsel, htrans, haddr} = {2'h3, 4'ha, 32'h0040_0500, 32'h0040_0400};
		@(posedge clock);
		#1 {hsel, htrans} = '0;
		repeat (4) @(posedge clock);
		#1 chk("port0 first", 2'h1, hready_out);
		repeat (5) @(posedge clock);
		#1 chk("port1 held off", 2'h1, hready_out);
		@(posedge clock);
		#1 chk("port1 served", 2'h3, hready_out);
		// Bank1 read while bank1 is busy programming, abort with note
		cfg(0, 32'h0000_4283);
		#1 {bank1_prog_busy, hsel[0], htrans[0], haddr[0]} = {1'b1, 1'b1, 2'h2, 32'h0040_0600};
		@(posedge clock);
		#1 {hsel[0], htrans[0]} = '0;
		@(posedge clock);
		#1 chk("read during write pulses", 3'h6, {bank1_rww_abort, rww_abort_note, rww_stall_note});
		bank1_prog_busy = 0;
		repeat (8) @(posedge clock);
		cfg(0, 32'h0000_42e2);
		xfer(rows[0]);
		xfer(rows[0]);
		cfg(1, 32'h0000_ffff);
		chk("protection write", 32'h0000_ffc0, cfg_rdata);
		xfer('{0, 0, 32'h0040_0000, 1, 2, 0});
		#1 rst = 1;
		repeat (2) @(posedge clock);
		#1 rst = 0;
		wait_boot();
		wrap_up();
	end
endmodule
